// *** include/temp_sense_pkg.sv ***
// shared constants, types and register map of the temperature result logic
package temp_sense_pkg;

	// ****************************************************************
	// register pointers
	// ****************************************************************
	localparam logic [2:0] PTR_TEMP = 3'h0;
	localparam logic [2:0] PTR_CFG  = 3'h1;
	localparam logic [2:0] PTR_THI  = 3'h2;
	localparam logic [2:0] PTR_TLO  = 3'h3;
	localparam logic [2:0] PTR_STAT = 3'h4;
	localparam logic [2:0] PTR_ID   = 3'h7;

	// ****************************************************************
	// field positions and values after reset
	// ****************************************************************
	localparam int         CFG_SHDN_BIT    = 7;
	localparam int         CFG_ONESHOT_BIT = 2;
	localparam int         STAT_RES_LSB    = 5;
	localparam int         STAT_DAV_BIT    = 0;
	localparam logic [15:0] TEMP_RST       = 16'h7FFC;
	localparam logic [15:0] TEMP_ONESHOT   = 16'h8000;
	localparam logic        SHDN_RST       = 1'h0;
	localparam logic [1:0]  RES_RST        = 2'h0;
	localparam logic [15:0] THI_RST        = 16'h0000;
	localparam logic [15:0] TLO_RST        = 16'h0000;
	localparam logic [15:0] RES_MASK_11    = 16'hFFE0;
	localparam logic [15:0] RES_MASK_12    = 16'hFFF0;
	localparam logic [15:0] RES_MASK_13    = 16'hFFF8;
	localparam logic [15:0] RES_MASK_14    = 16'hFFFC;
	localparam logic [6:0]  DEV_ADDR_DEF   = 7'h48;
	// arbitrary identification value
	localparam logic [15:0] ID_VALUE_DEF   = 16'h0A5A;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CORE_CLK_NS    = 8;
	localparam int CONV_CLK_NS    = 160;
	localparam int TIMEOUT_MIN_US = 15000;
	localparam int TIMEOUT_MAX_US = 45000;
	localparam int TIMEOUT_US     = 30000;
	localparam int TIMEOUT_CYC    = TIMEOUT_US * 1000 / CORE_CLK_NS;
	localparam int CONV_TIME_US   = 14000;
	localparam int CONV_CYC       = CONV_TIME_US * 1000 / CONV_CLK_NS;
	localparam int POR_COMM_US    = 1;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_ADDR = 3'b001,
		SER_ACK  = 3'b010,
		SER_PTR  = 3'b011,
		SER_WR   = 3'b100,
		SER_RD   = 3'b101,
		SER_RACK = 3'b110
	} ser_state_t;

	typedef struct packed {
		logic [1:0] res;
	} conv_req_t;

	typedef struct packed {
		logic        en;
		logic [2:0]  addr;
		logic [15:0] data;
	} reg_wr_t;

endpackage

// *** hdl/temp_conversion_result_logic.sv ***
// conversion control, result formatting and serial slave of the sensor
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// How it works
// R1: a serial line stuck low past the timeout idles the slave and releases data
// R2: stuck-low timeout lies between 15 and 45 ms; masters stay well below
// R3: an unsupported pointer byte is not acknowledged and the old pointer stays
// R4: the result register is readable at any time, giving the last result
// R5: the bus is usable right after reset, well within 1 us
// R6: a valid result appears one conversion period after reset release
// R7: every register takes a defined value at reset until updated or written
// R8: the result register resets to 7FFC
// R9: in shutdown, writing one-shot runs exactly one conversion and update
// R10: during a one-shot conversion the ready flag is 0, result reads 8000
// R11: a one-shot conversion leaves all other registers untouched
// R12: a finished conversion sets the ready flag and loads the result
// R13: two resolution bits pick 11, 12, 13 or 14 bit words
// R14: resolution resets to the 11 bit word, 0.25 degree steps
// R15: result is two's complement, left aligned, sign in bit 15
// R16: result bits below the chosen resolution read as zero
// R17: outside shutdown conversions run back to back, updating each time
module temp_conversion_result_logic #(
	parameter int          TIMEOUT_CYC = temp_sense_pkg::TIMEOUT_CYC,
	parameter int          CONV_CYC    = temp_sense_pkg::CONV_CYC,
	parameter logic [6:0]  DEV_ADDR    = temp_sense_pkg::DEV_ADDR_DEF,
	parameter logic [15:0] ID_VALUE    = temp_sense_pkg::ID_VALUE_DEF
) (
	// core clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// conversion clock domain
	input  wire logic        conv_clk,
	input  wire logic [13:0] adc_result,
	// register port
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// serial pins
	input  wire logic        serial_clock_pin,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	// status
	output logic             result_ready_flag,
	output logic             conv_busy
);

	localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
	localparam int CV_W = $clog2(CONV_CYC * 8 + 1);

	if (TIMEOUT_CYC < 1 || CONV_CYC < 1) begin : g_bad_param
		$error("timeout and conversion counts must be at least one");
	end

	// ****************************************************************
	// pin synchronisers and glitch filter
	// ****************************************************************
	logic [2:0]    scl_sync_ff;
	logic [2:0]    sda_sync_ff;
	logic          scl_f_ff;
	logic          sda_f_ff;
	logic          scl_prev_ff;
	logic          sda_prev_ff;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
		end else if (clk_en) begin
			scl_sync_ff <= {scl_sync_ff[1:0], serial_clock_pin};
			sda_sync_ff <= {sda_sync_ff[1:0], serial_data_in};
		end
	end

	// a level only counts once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_f_ff    <= 1'h1;
			sda_f_ff    <= 1'h1;
			scl_prev_ff <= 1'h1;
			sda_prev_ff <= 1'h1;
		end else if (clk_en) begin
			if (scl_sync_ff[1] == scl_sync_ff[2])
				scl_f_ff <= scl_sync_ff[2];
			if (sda_sync_ff[1] == sda_sync_ff[2])
				sda_f_ff <= sda_sync_ff[2];
			scl_prev_ff <= scl_f_ff;
			sda_prev_ff <= sda_f_ff;
		end
	end

	wire scl_rise  = scl_f_ff & ~scl_prev_ff;
	wire scl_fall  = ~scl_f_ff & scl_prev_ff;
	wire bus_start = scl_f_ff & scl_prev_ff & ~sda_f_ff & sda_prev_ff;
	wire bus_stop  = scl_f_ff & scl_prev_ff & sda_f_ff & ~sda_prev_ff;

	// ****************************************************************
	// stuck-line timeout
	// ****************************************************************
	logic [TO_W-1:0] stuck_cnt_ff;
	wire             line_low  = ~scl_f_ff | ~sda_f_ff;
	wire             timed_out = (stuck_cnt_ff == TO_W'(TIMEOUT_CYC));

	// counter saturates so the slave stays idle while the line stays low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			stuck_cnt_ff <= '0;
		else if (clk_en) begin
			if (!line_low)
				stuck_cnt_ff <= '0;
			else if (!timed_out)
				stuck_cnt_ff <= stuck_cnt_ff + 1'b1; // see R2
		end
	end

	// ****************************************************************
	// register file state
	// ****************************************************************
	logic        shdn_ff;
	logic [1:0]  res_ff;
	logic [15:0] thi_ff;
	logic [15:0] tlo_ff;
	logic [15:0] temp_ff;
	logic        dav_ff;
	logic [2:0]  ptr_ff;
	logic        ser_we_ff;
	logic [15:0] ser_wd_ff;

	function automatic logic [15:0] reg_value(input logic [2:0] a,
		input logic [15:0] t, input logic s, input logic [1:0] r,
		input logic [15:0] hi, input logic [15:0] lo, input logic d);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			temp_sense_pkg::PTR_TEMP: v = t;
			temp_sense_pkg::PTR_CFG:
				v[temp_sense_pkg::CFG_SHDN_BIT] = s;
			temp_sense_pkg::PTR_THI:  v = hi;
			temp_sense_pkg::PTR_TLO:  v = lo;
			temp_sense_pkg::PTR_STAT: begin
				v[temp_sense_pkg::STAT_RES_LSB +: 2] = r;
				v[temp_sense_pkg::STAT_DAV_BIT]      = d;
			end
			temp_sense_pkg::PTR_ID:   v = ID_VALUE;
			default:                  v = 16'h0000;
		endcase
		return v;
	endfunction

	function automatic logic [15:0] res_mask(input logic [1:0] r);
		logic [15:0] m;
		m = temp_sense_pkg::RES_MASK_11;
		case (r)
			2'h0: m = temp_sense_pkg::RES_MASK_11;
			2'h1: m = temp_sense_pkg::RES_MASK_12;
			2'h2: m = temp_sense_pkg::RES_MASK_13;
			2'h3: m = temp_sense_pkg::RES_MASK_14;
		endcase
		return m;
	endfunction

	// register port write has priority over a serial write in the same cycle
	temp_sense_pkg::reg_wr_t wr;
	assign wr.en   = reg_wr | ser_we_ff;
	assign wr.addr = reg_wr ? reg_addr : ptr_ff;
	assign wr.data = reg_wr ? reg_wdata : ser_wd_ff;

	wire cfg_wr     = wr.en & (wr.addr == temp_sense_pkg::PTR_CFG);
	wire stat_wr    = wr.en & (wr.addr == temp_sense_pkg::PTR_STAT);
	wire oneshot_wr = cfg_wr & wr.data[temp_sense_pkg::CFG_ONESHOT_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shdn_ff <= temp_sense_pkg::SHDN_RST;    // see R7
			res_ff  <= temp_sense_pkg::RES_RST;     // see R14
			thi_ff  <= temp_sense_pkg::THI_RST;
			tlo_ff  <= temp_sense_pkg::TLO_RST;
		end else if (clk_en) begin
			if (cfg_wr)
				shdn_ff <= wr.data[temp_sense_pkg::CFG_SHDN_BIT];
			if (stat_wr)
				res_ff <= wr.data[temp_sense_pkg::STAT_RES_LSB +: 2]; // see R13
			if (wr.en && wr.addr == temp_sense_pkg::PTR_THI)
				thi_ff <= wr.data;
			if (wr.en && wr.addr == temp_sense_pkg::PTR_TLO)
				tlo_ff <= wr.data;
		end
	end

	// read data stand one cycle after the strobe and only then
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (clk_en)
			reg_rdata <= reg_rd ? reg_value(reg_addr, temp_ff, shdn_ff,
				res_ff, thi_ff, tlo_ff, dav_ff) : 16'h0000; // see R4
	end

	// ****************************************************************
	// conversion control, core side
	// ****************************************************************
	logic                      req_tog_ff;
	temp_sense_pkg::conv_req_t req_ff;
	logic                      os_pend_ff;
	logic [2:0]                done_sync_ff;
	logic                      done_seen_ff;
	logic                      done_tog_ff;
	logic [13:0]               conv_data_ff;

	wire done_evt   = (done_sync_ff[1] == done_sync_ff[2]) &
		(done_sync_ff[2] != done_seen_ff);
	wire start_conv = ~conv_busy & (~shdn_ff | os_pend_ff); // see R17
	// conversion data are held steady until the next conversion ends
	wire [15:0] new_temp = {conv_data_ff, 2'b00} & res_mask(req_ff.res);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_sync_ff <= 3'h0;
			done_seen_ff <= 1'h0;
		end else if (clk_en) begin
			done_sync_ff <= {done_sync_ff[1:0], done_tog_ff};
			if (done_sync_ff[1] == done_sync_ff[2])
				done_seen_ff <= done_sync_ff[2];
		end
	end

	// a one-shot written while a free-running conversion ends is kept pending
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			os_pend_ff <= 1'h0;
		else if (clk_en) begin
			if (oneshot_wr && shdn_ff)
				os_pend_ff <= 1'h1;                 // see R9
			else if (start_conv)
				os_pend_ff <= 1'h0;
		end
	end

	// first conversion begins right after reset release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_tog_ff <= 1'h0;
			req_ff     <= '0;
			conv_busy  <= 1'h0;
			temp_ff    <= temp_sense_pkg::TEMP_RST; // see R8
			dav_ff     <= 1'h0;
		end else if (clk_en) begin
			if (start_conv) begin
				req_tog_ff <= ~req_tog_ff;          // see R6
				req_ff.res <= res_ff;
				conv_busy  <= 1'h1;
				if (shdn_ff) begin
					// only result and flag change here
					temp_ff <= temp_sense_pkg::TEMP_ONESHOT; // see R10, R11
					dav_ff  <= 1'h0;
				end
			end else if (done_evt) begin
				conv_busy <= 1'h0;
				temp_ff   <= new_temp;              // see R12, R15, R16
				dav_ff    <= 1'h1;                  // see R12
			end
		end
	end

	assign result_ready_flag = dav_ff;

	// ****************************************************************
	// conversion timer, conversion clock side
	// ****************************************************************
	logic [1:0]      crst_ff;
	logic [2:0]      req_sync_ff;
	logic            req_seen_ff;
	logic            running_ff;
	logic [CV_W-1:0] ccnt_ff;
	logic [CV_W-1:0] clen_ff;

	wire conv_rst_n = crst_ff[1];
	wire req_evt    = (req_sync_ff[1] == req_sync_ff[2]) &
		(req_sync_ff[2] != req_seen_ff);
	// higher resolution doubles the conversion time per step
	wire [CV_W-1:0] conv_len = CV_W'(CONV_CYC) << req_ff.res;

	always_ff @(posedge conv_clk or negedge rst_n) begin
		if (!rst_n)
			crst_ff <= 2'h0;
		else
			crst_ff <= {crst_ff[0], 1'b1};
	end

	always_ff @(posedge conv_clk or negedge conv_rst_n) begin
		if (!conv_rst_n) begin
			req_sync_ff <= 3'h0;
			req_seen_ff <= 1'h0;
		end else begin
			req_sync_ff <= {req_sync_ff[1:0], req_tog_ff};
			if (req_sync_ff[1] == req_sync_ff[2])
				req_seen_ff <= req_sync_ff[2];
		end
	end

	always_ff @(posedge conv_clk or negedge conv_rst_n) begin
		if (!conv_rst_n) begin
			running_ff   <= 1'h0;
			ccnt_ff      <= '0;
			clen_ff      <= '0;
			conv_data_ff <= 14'h0000;
			done_tog_ff  <= 1'h0;
		end else if (req_evt) begin
			running_ff <= 1'h1;
			ccnt_ff    <= '0;
			clen_ff    <= conv_len - 1'b1;
		end else if (running_ff) begin
			if (ccnt_ff == clen_ff) begin
				running_ff   <= 1'h0;
				conv_data_ff <= adc_result;
				done_tog_ff  <= ~done_tog_ff;
			end else
				ccnt_ff <= ccnt_ff + 1'b1;
		end
	end

	// ****************************************************************
	// serial slave
	// ****************************************************************
	temp_sense_pkg::ser_state_t st_ff;
	temp_sense_pkg::ser_state_t after_ff;
	logic [7:0] sh_ff;
	logic [2:0] bit_ff;
	logic       ack_ok_ff;
	logic       phase_ff;
	logic       byte_ff;
	logic [7:0] stash_ff;
	logic [7:0] tx_ff;

	wire [7:0]  byte_in  = {sh_ff[6:0], sda_f_ff};
	wire        last_bit = scl_rise & (bit_ff == 3'h7);
	wire        ptr_ok   = (byte_in[7:3] == 5'h00) &
		((byte_in[2:0] <= temp_sense_pkg::PTR_STAT) |
		 (byte_in[2:0] == temp_sense_pkg::PTR_ID));
	wire        two_byte = (ptr_ff != temp_sense_pkg::PTR_CFG) &
		(ptr_ff != temp_sense_pkg::PTR_STAT);
	wire [15:0] ptr_val  = reg_value(ptr_ff, temp_ff, shdn_ff, res_ff,
		thi_ff, tlo_ff, dav_ff);
	// one-byte registers repeat their byte on longer reads
	wire [7:0]  tx_byte  = (two_byte & ~byte_ff) ? ptr_val[15:8] :
		ptr_val[7:0];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_data_out <= 1'h0;
			st_ff          <= temp_sense_pkg::SER_IDLE; // see R5
			after_ff       <= temp_sense_pkg::SER_IDLE;
			sh_ff          <= 8'h00;
			bit_ff         <= 3'h0;
			ack_ok_ff      <= 1'h0;
			phase_ff       <= 1'h0;
			byte_ff        <= 1'h0;
			stash_ff       <= 8'h00;
			tx_ff          <= 8'h00;
			ptr_ff         <= temp_sense_pkg::PTR_TEMP;
			ser_we_ff      <= 1'h0;
			ser_wd_ff      <= 16'h0000;
			serial_data_oe <= 1'h0;
		end else if (clk_en) begin
			ser_we_ff <= 1'h0;
			if (timed_out) begin
				st_ff          <= temp_sense_pkg::SER_IDLE; // see R1
				serial_data_oe <= 1'h0;                     // see R1
				phase_ff       <= 1'h0;
			end else if (bus_start) begin
				st_ff          <= temp_sense_pkg::SER_ADDR;
				bit_ff         <= 3'h0;
				byte_ff        <= 1'h0;
				phase_ff       <= 1'h0;
				serial_data_oe <= 1'h0;
			end else if (bus_stop) begin
				st_ff          <= temp_sense_pkg::SER_IDLE;
				serial_data_oe <= 1'h0;
			end else begin
				if (scl_rise && (st_ff == temp_sense_pkg::SER_ADDR ||
					st_ff == temp_sense_pkg::SER_PTR ||
					st_ff == temp_sense_pkg::SER_WR ||
					st_ff == temp_sense_pkg::SER_RD)) begin
					sh_ff  <= byte_in;
					bit_ff <= bit_ff + 1'b1;
				end
				unique case (st_ff)
					temp_sense_pkg::SER_IDLE: ;
					temp_sense_pkg::SER_ADDR: if (last_bit) begin
						ack_ok_ff <= 1'h1;
						phase_ff  <= 1'h0;
						after_ff  <= byte_in[0] ? temp_sense_pkg::SER_RD :
							temp_sense_pkg::SER_PTR;
						st_ff     <= (byte_in[7:1] == DEV_ADDR) ?
							temp_sense_pkg::SER_ACK : temp_sense_pkg::SER_IDLE;
					end
					temp_sense_pkg::SER_PTR: if (last_bit) begin
						ack_ok_ff <= ptr_ok;                // see R3
						if (ptr_ok)
							ptr_ff <= byte_in[2:0];         // see R3
						byte_ff   <= 1'h0;
						phase_ff  <= 1'h0;
						after_ff  <= temp_sense_pkg::SER_WR;
						st_ff     <= temp_sense_pkg::SER_ACK;
					end
					temp_sense_pkg::SER_WR: if (last_bit) begin
						if (two_byte && !byte_ff) begin
							stash_ff <= byte_in;
							byte_ff  <= 1'h1;
						end else begin
							ser_we_ff <= 1'h1;
							ser_wd_ff <= two_byte ? {stash_ff, byte_in} :
								{8'h00, byte_in};
							byte_ff   <= 1'h0;
						end
						ack_ok_ff <= 1'h1;
						phase_ff  <= 1'h0;
						after_ff  <= temp_sense_pkg::SER_WR;
						st_ff     <= temp_sense_pkg::SER_ACK;
					end
					temp_sense_pkg::SER_ACK: if (scl_fall) begin
						if (!phase_ff) begin
							phase_ff       <= 1'h1;
							serial_data_oe <= ack_ok_ff;
						end else begin
							phase_ff <= 1'h0;
							bit_ff   <= 3'h0;
							if (!ack_ok_ff) begin
								st_ff          <= temp_sense_pkg::SER_IDLE;
								serial_data_oe <= 1'h0;
							end else if (after_ff == temp_sense_pkg::SER_RD) begin
								st_ff          <= temp_sense_pkg::SER_RD;
								tx_ff          <= tx_byte;
								serial_data_oe <= ~tx_byte[7];
							end else begin
								st_ff          <= after_ff;
								serial_data_oe <= 1'h0;
							end
						end
					end
					temp_sense_pkg::SER_RD: begin
						if (last_bit)
							st_ff <= temp_sense_pkg::SER_RACK;
						else if (scl_fall) begin
							tx_ff          <= {tx_ff[6:0], 1'b0};
							serial_data_oe <= ~tx_ff[6];
						end
					end
					temp_sense_pkg::SER_RACK: begin
						// the master's acknowledge asks for another byte
						if (scl_rise) begin
							if (!sda_f_ff) begin
								phase_ff <= 1'h1;
								byte_ff  <= ~byte_ff;
							end else
								st_ff <= temp_sense_pkg::SER_IDLE;
						end else if (scl_fall) begin
							if (phase_ff) begin
								phase_ff       <= 1'h0;
								bit_ff         <= 3'h0;
								st_ff          <= temp_sense_pkg::SER_RD;
								tx_ff          <= tx_byte;
								serial_data_oe <= ~tx_byte[7];
							end else
								serial_data_oe <= 1'h0;
						end
					end
					default: st_ff <= temp_sense_pkg::SER_IDLE;
				endcase
			end
		end
	end

endmodule

// *** sim/temp_result_chk.sv ***
// assertion checker for the temperature result logic ports
`timescale 1ns/1ps
module temp_result_chk #(
	parameter int          TIMEOUT_CYC = 200,
	parameter logic [15:0] ID_VALUE    = 16'h0000
) (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// register port
	input wire logic [2:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// serial pins and status
	input wire logic        serial_clock_pin,
	input wire logic        serial_data_in,
	input wire logic        serial_data_oe,
	input wire logic        result_ready_flag,
	input wire logic        conv_busy
);
	// ****
	// helper state
	// ****
	logic [31:0] low_cnt_ff;
	logic        shut_ff;
	logic        done_ff;
	wire         cfg_wr;
	wire         bus_up;
	assign cfg_wr = reg_wr && reg_addr == temp_sense_pkg::PTR_CFG;
	assign bus_up = serial_clock_pin && serial_data_in;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_ff <= '0;
			shut_ff    <= 1'b0;
			done_ff    <= 1'b0;
		end else begin
			low_cnt_ff <= bus_up ? '0 : low_cnt_ff + 32'h1;
			if (cfg_wr) begin
				shut_ff <= reg_wdata[temp_sense_pkg::CFG_SHDN_BIT];
			end
			done_ff <= done_ff | result_ready_flag;
		end
	end
	// ****
	// properties
	// ****
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence temp_rd_s;
		reg_rd && reg_addr == temp_sense_pkg::PTR_TEMP;
	endsequence
	sequence conv_end_s;
		$fell(conv_busy);
	endsequence
	reset_temp_a: assert property (
		(!done_ff && !result_ready_flag) ##0 temp_rd_s
		|=> reg_rdata == temp_sense_pkg::TEMP_RST) else $error("temp not at reset");
	temp_lsb_a: assert property (
		temp_rd_s |=> reg_rdata[1:0] == 2'h0) else $error("temp low bits set");
	id_value_a: assert property (
		reg_rd && reg_addr == temp_sense_pkg::PTR_ID |=> reg_rdata == ID_VALUE)
		else $error("id value wrong");
	flag_clear_a: assert property (
		$fell(result_ready_flag) |-> conv_busy) else $error("flag fell idle");
	oneshot_temp_a: assert property (
		(done_ff && !result_ready_flag && conv_busy) ##0 temp_rd_s
		|=> reg_rdata == temp_sense_pkg::TEMP_ONESHOT)
		else $error("one-shot temp wrong");
	done_flag_a: assert property (
		conv_end_s |-> ##[0:2] result_ready_flag) else $error("flag not set");
	free_run_a: assert property (
		conv_end_s ##0 !shut_ff |-> ##[1:3] conv_busy)
		else $error("free run stopped");
	shut_idle_a: assert property (
		shut_ff && !conv_busy && !cfg_wr && !$past(cfg_wr) && !$past(cfg_wr, 2)
		|=> !conv_busy) else $error("conversion in shutdown");
	timeout_rel_a: assert property (
		low_cnt_ff > TIMEOUT_CYC + 12 |-> !serial_data_oe)
		else $error("data line held after timeout");
endmodule

bind temp_conversion_result_logic temp_result_chk #(
	.TIMEOUT_CYC(TIMEOUT_CYC),
	.ID_VALUE   (ID_VALUE)
) chk_i (.*);

// *** sim/smb_host.sv ***
// two-wire bus master model facing the sensor's serial pins
`timescale 1ns/1ps
module smb_host #(
	parameter int TO_NS = 1600
) (
	// bus lines; line is the wired data level with pull-up
	output logic      scl,
	output logic      sda,
	input  wire logic line
);
	localparam logic [7:0] ADW = {temp_sense_pkg::DEV_ADDR_DEF, 1'b0};
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// data moves only while the clock is low; low phases stay short
	task automatic bit_io(input logic b, output logic r);
		sda = b;
		#200;
		scl = 1'b1;
		#400;
		r = line;
		scl = 1'b0;
		#200;
	endtask
	task automatic start();
		sda = 1'b0;
		#400;
		scl = 1'b0;
		#200;
	endtask
	task automatic stop();
		sda = 1'b0;
		#200;
		scl = 1'b1;
		#400;
		sda = 1'b1;
		#1200;
	endtask
	task automatic put(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic write_ptr(input logic [7:0] p, output logic ack);
		logic a;
		start();
		put(ADW, a);
		put(p, ack);
		stop();
	endtask
	task automatic read_msb(output logic [7:0] v);
		logic a;
		start();
		put(ADW | 8'h01, a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, v[i]);
		end
		bit_io(1'b1, a);
		stop();
	endtask
	// clock held low in the ack slot, 800 ns past the stuck-bus limit
	task automatic stall(output logic oe_on, output logic oe_off);
		logic r;
		start();
		for (int i = 7; i >= 0; i--) begin
			bit_io(ADW[i], r);
		end
		sda = 1'b1;
		#200;
		oe_on = !line;
		#(TO_NS + 800);
		oe_off = !line;
		scl = 1'b1;
		#400;
		scl = 1'b0;
		#200;
		stop();
	endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the temperature result logic
`timescale 1ns/1ps
module tb_top;
	localparam logic [2:0] A_TEMP = temp_sense_pkg::PTR_TEMP;
	localparam logic [2:0] A_CFG  = temp_sense_pkg::PTR_CFG;
	localparam logic [2:0] A_STAT = temp_sense_pkg::PTR_STAT;
	logic        core_clk   = 1'b0;
	logic        conv_clk   = 1'b0;
	logic        rst_n      = 1'b0;
	logic [13:0] adc_result = 14'h0000;
	logic [2:0]  reg_addr   = 3'h0;
	logic [15:0] reg_wdata  = 16'h0000;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic [15:0] reg_rdata;
	logic        scl;
	logic        sda;
	logic        line;
	logic        d_out;
	logic        d_oe;
	logic        result_ready_flag;
	logic        conv_busy;
	int          error_cnt  = 0;
	int          num_checks = 0;
	int          cyc        = 0;
	logic [31:0] seed       = 32'hBE41;
	// open-drain data line with pull-up
	assign line = sda & ~(d_oe & ~d_out);
	temp_conversion_result_logic #(
		.TIMEOUT_CYC(2000),
		.CONV_CYC   (20)
	) uut (
		.core_clk         (core_clk),
		.rst_n            (rst_n),
		.clk_en           (1'b1),
		.conv_clk         (conv_clk),
		.adc_result       (adc_result),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.reg_rdata        (reg_rdata),
		.serial_clock_pin (scl),
		.serial_data_in   (line),
		.serial_data_out  (d_out),
		.serial_data_oe   (d_oe),
		.result_ready_flag(result_ready_flag),
		.conv_busy        (conv_busy)
	);
	smb_host #(.TO_NS(16000)) m (.scl(scl), .sda(sda), .line(line));
	initial forever #4 core_clk = ~core_clk;
	initial begin
		#37;
		forever #80 conv_clk = ~conv_clk;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	function automatic logic [15:0] exp_temp(input logic [13:0] a,
		input logic [1:0] r);
		return {a, 2'b00} & (16'hFFFF << (3'h5 - r));
	endfunction
	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] q);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		q = reg_rdata;
	endtask
	// the gap between free-running conversions lasts one cycle
	task automatic wait_done();
		do @(posedge core_clk); while (conv_busy !== 1'b0);
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		logic [15:0] q;
		logic [15:0] thi;
		logic [15:0] rtab [8];
		logic [7:0]  b;
		logic        a0;
		logic        a1;
		rtab = '{16'h7FFC, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
			16'h0000, 16'h0000, temp_sense_pkg::ID_VALUE_DEF};
		seed = xorshift(seed);
		adc_result <= seed[13:0];
		repeat (4) @(posedge conv_clk);
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), q);
			chk("reset value", q, rtab[i]);
		end
		wr(A_TEMP, 16'h1234);
		rd(A_TEMP, q);
		chk("temp read only", q, 16'h7FFC);
		chk("early flag", 16'(result_ready_flag), 16'h0000);
		wait_done();
		rd(A_TEMP, q);
		chk("first result", q, exp_temp(adc_result, 2'h0));
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			seed = xorshift(seed);
			adc_result <= i == 4 ? 14'h1FFF : i == 5 ? 14'h2000 : seed[13:0];
			wr(A_STAT, 16'(i % 4) << 5);
			wait_done();
			wait_done();
			rd(A_TEMP, q);
			chk("temp", q, exp_temp(adc_result, 2'(i % 4)));
			rd(A_STAT, q);
			chk("status", q & 16'h0061, (16'(i % 4) << 5) | 16'h1);
		end
		$display("test resolution done");
		wr(A_CFG, 16'h0080);
		wait_done();
		seed = xorshift(seed);
		thi = seed[31:16] & 16'hFFE0;
		adc_result <= seed[13:0];
		wr(temp_sense_pkg::PTR_THI, thi);
		repeat (50) @(posedge core_clk);
		chk("idle in shutdown", 16'(conv_busy), 16'h0000);
		wr(A_CFG, 16'h0084);
		repeat (3) @(posedge core_clk);
		rd(A_TEMP, q);
		chk("one-shot temp", q, 16'h8000);
		rd(A_STAT, q);
		chk("one-shot status", q & 16'h0061, 16'h0020);
		rd(temp_sense_pkg::PTR_THI, q);
		chk("limit kept", q, thi);
		rd(A_CFG, q);
		chk("config kept", q, 16'h0080);
		wait_done();
		rd(A_TEMP, q);
		chk("one-shot result", q, exp_temp(adc_result, 2'h1));
		chk("flag set", 16'(result_ready_flag), 16'h0001);
		repeat (600) @(posedge core_clk);
		chk("single conversion", 16'(conv_busy), 16'h0000);
		$display("test one-shot done");
		m.write_ptr(8'h02, a0);
		chk("pointer ack", 16'(a0), 16'h0001);
		m.write_ptr(8'h05, a0);
		m.write_ptr(8'h0A, a1);
		chk("bad pointer nack", 16'({a0, a1}), 16'h0000);
		m.read_msb(b);
		chk("pointer kept", 16'(b), 16'(thi[15:8]));
		m.stall(a0, a1);
		chk("ack driven", 16'(a0), 16'h0001);
		chk("bus released", 16'(a1), 16'h0000);
		$display("test serial done");
		complete_run();
	end
endmodule
